// [core/sram_host_defines.svh]
// Timing and field constants for the asynchronous static memory host controller
`ifndef SRAM_HOST_DEFINES_SVH
`define SRAM_HOST_DEFINES_SVH

`define ADDR_W 16
`define DATA_W 16
`define LOW_LANE_LSB 0
`define HIGH_LANE_LSB 8
`define LANE_W 8
`define TIMER_W 17

`define CLK_PERIOD_NS 40
// Slowest grade figures, so every grade is served
`define T_AA_NS 15
`define T_WP_NS 12
`define T_WC_NS 15
`define T_DW_NS 8
`define T_OHZ_NS 7
`define T_RDR_MS 5
`define SYNC_CYC 2

// Minimums and maximums both round up to whole cycles
`define NS_TO_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACC_CYC `NS_TO_CYC(`T_AA_NS)
`define WP_CYC `NS_TO_CYC(`T_WC_NS)
`define HZ_CYC `NS_TO_CYC(`T_OHZ_NS)
`define RDR_CYC_DEF ((`T_RDR_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [core/sram_host_pkg.sv]
// Types shared by the static memory host controller
package sram_host_pkg;
    `include "sram_host_defines.svh"

    typedef struct packed {
        logic chip_sel_n;
        logic write_en_n;
        logic out_en_n;
        logic high_byte_en_n;
        logic low_byte_en_n;
    } sram_ctl_type;

    typedef struct packed {
        logic write;
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
        logic high_byte_en_n;
        logic low_byte_en_n;
    } host_req_type;

    localparam sram_ctl_type CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage

// [core/sram_host_timer.sv]
// Down counter that measures a wait in clock cycles
module sram_host_timer
    import sram_host_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Control
    input wire logic i_start,
    input wire logic [`TIMER_W-1:0] i_count,
    output logic o_done
);
    logic [`TIMER_W-1:0] cnt;
    logic [`TIMER_W-1:0] next_cnt;

    always_comb begin
        next_cnt = cnt;
        if (i_start) begin
            // Wait of i_count cycles; counts of zero are treated as one
            next_cnt = (i_count == '0) ? '0 : i_count - `TIMER_W'(1);
        end else if (cnt != '0) begin
            next_cnt = cnt - `TIMER_W'(1);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    // Done ignores start, so a state may restart the timer off done without a loop
    assign o_done = (cnt == '0);
endmodule // sram_host_timer

// [core/sram_host_ctrl.sv]
// Host controller driving a 64K x 16 asynchronous static memory
// Overview of operation
// - Host holds the write strobe high throughout every read.
// - Host spaces successive writes at least one write cycle time apart.
// - Address is stable no later than the write interval start.
// - Address is held valid for the address-to-end time of the write.
// - Select is held low for the select-to-end time of the write.
// - Address may change right when the write interval ends.
// - Write data may be removed right when the write interval ends.
// - Host never drives the data lines while the memory may drive them.
// - Host waits 5 ms after low-supply retention before any access.
module sram_host_ctrl
    import sram_host_pkg::*;
#(
    parameter int unsigned RDR_CYC = `RDR_CYC_DEF
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Host request side
    input wire logic i_req_valid,
    input wire host_req_type i_req,
    output logic o_req_ready,
    // Read answer
    output logic o_rd_valid,
    output logic [`DATA_W-1:0] o_rd_data,
    // Supply state from power logic
    input wire logic i_low_supply,
    // Memory pins
    output logic [`ADDR_W-1:0] o_sram_addr,
    output sram_ctl_type o_sram_ctl,
    output logic [`DATA_W-1:0] o_dq_out,
    output logic o_dq_oe,
    input wire logic [`DATA_W-1:0] i_dq_in
);
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RD_ACC,
        ST_RD_SYNC,
        ST_RD_CAP,
        ST_RD_OFF,
        ST_WR_PULSE,
        ST_WR_END,
        ST_LOW_SUPPLY,
        ST_RECOVER
    } state_type;

    state_type state;
    state_type next_state;
    host_req_type op;
    host_req_type next_op;
    sram_ctl_type next_ctl;
    logic [`ADDR_W-1:0] next_addr;
    logic [`DATA_W-1:0] next_dq_out;
    logic next_dq_oe;
    logic next_rd_valid;
    logic [`DATA_W-1:0] next_rd_data;
    logic tmr_start;
    logic [`TIMER_W-1:0] tmr_count;
    logic tmr_done;

    // Pin inputs pass three flops; a value counts once the last two agree
    logic [`DATA_W-1:0] dq_s1;
    logic [`DATA_W-1:0] dq_s2;
    logic [`DATA_W-1:0] dq_s3;
    logic sup_s1;
    logic sup_s2;
    logic sup_s3;
    logic supply_low;
    logic next_supply_low;
    logic [`DATA_W-1:0] lane_mask;

    sram_host_timer u_timer (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_start(tmr_start),
        .i_count(tmr_count),
        .o_done(tmr_done)
    );

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dq_s1 <= '0;
            dq_s2 <= '0;
            dq_s3 <= '0;
            sup_s1 <= 1'b0;
            sup_s2 <= 1'b0;
            sup_s3 <= 1'b0;
        end else begin
            dq_s1 <= i_dq_in;
            dq_s2 <= dq_s1;
            dq_s3 <= dq_s2;
            sup_s1 <= i_low_supply;
            sup_s2 <= sup_s1;
            sup_s3 <= sup_s2;
        end
    end

    // Disabled lanes float, so their bits read as zero
    assign lane_mask = {{`LANE_W{!op.high_byte_en_n}}, {`LANE_W{!op.low_byte_en_n}}};

    always_comb begin
        next_supply_low = (sup_s2 == sup_s3) ? sup_s3 : supply_low;
        next_state = state;
        next_op = op;
        tmr_start = 1'b0;
        tmr_count = '0;
        next_rd_valid = 1'b0;
        next_rd_data = o_rd_data;
        case (state)
            ST_IDLE: begin
                if (supply_low) begin
                    next_state = ST_LOW_SUPPLY;
                end else if (i_req_valid) begin
                    next_op = i_req;
                    tmr_start = 1'b1;
                    if (i_req.write) begin
                        next_state = ST_WR_PULSE;
                        tmr_count = `TIMER_W'(`WP_CYC);
                    end else begin
                        next_state = ST_RD_ACC;
                        tmr_count = `TIMER_W'(`ACC_CYC);
                    end
                end
            end
            ST_RD_ACC: begin
                if (tmr_done) begin
                    next_state = ST_RD_SYNC;
                    tmr_start = 1'b1;
                    tmr_count = `TIMER_W'(`SYNC_CYC);
                end
            end
            ST_RD_SYNC: begin
                if (tmr_done) begin
                    next_state = ST_RD_CAP;
                end
            end
            ST_RD_CAP: begin
                if (dq_s2 == dq_s3) begin
                    next_rd_data = dq_s3 & lane_mask;
                    next_rd_valid = 1'b1;
                    next_state = ST_RD_OFF;
                    tmr_start = 1'b1;
                    // Bus turnaround before the host may drive again
                    tmr_count = `TIMER_W'(`HZ_CYC);
                end
            end
            ST_RD_OFF: begin
                if (tmr_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_WR_PULSE: begin
                if (tmr_done) begin
                    next_state = ST_WR_END;
                end
            end
            ST_WR_END: begin
                next_state = ST_IDLE;
            end
            ST_LOW_SUPPLY: begin
                if (!supply_low) begin
                    next_state = ST_RECOVER;
                    tmr_start = 1'b1;
                    tmr_count = `TIMER_W'(RDR_CYC);
                end
            end
            ST_RECOVER: begin
                if (supply_low) begin
                    next_state = ST_LOW_SUPPLY;
                end else if (tmr_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Pins follow the coming state so each output leaves a flop
    always_comb begin
        next_ctl = CTL_IDLE;
        next_addr = o_sram_addr;
        next_dq_out = o_dq_out;
        next_dq_oe = 1'b0;
        case (next_state)
            ST_RD_ACC, ST_RD_SYNC, ST_RD_CAP: begin
                next_addr = next_op.addr;
                next_ctl.chip_sel_n = 1'b0;
                next_ctl.out_en_n = 1'b0;
                next_ctl.write_en_n = 1'b1;
                next_ctl.high_byte_en_n = next_op.high_byte_en_n;
                next_ctl.low_byte_en_n = next_op.low_byte_en_n;
            end
            ST_WR_PULSE: begin
                // Address, data, select and strobe move on one edge
                next_addr = next_op.addr;
                next_dq_out = next_op.wdata;
                next_dq_oe = 1'b1;
                next_ctl.chip_sel_n = 1'b0;
                next_ctl.write_en_n = 1'b0;
                next_ctl.out_en_n = 1'b1;
                next_ctl.high_byte_en_n = next_op.high_byte_en_n;
                next_ctl.low_byte_en_n = next_op.low_byte_en_n;
            end
            ST_WR_END: begin
                // Strobe and select rise together; data and address may go now
                next_ctl = CTL_IDLE;
            end
            default: begin
                next_ctl = CTL_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
            op <= '0;
            supply_low <= 1'b0;
            o_sram_ctl <= CTL_IDLE;
            o_sram_addr <= '0;
            o_dq_out <= '0;
            o_dq_oe <= 1'b0;
            o_rd_valid <= 1'b0;
            o_rd_data <= '0;
        end else begin
            state <= next_state;
            op <= next_op;
            supply_low <= next_supply_low;
            o_sram_ctl <= next_ctl;
            o_sram_addr <= next_addr;
            o_dq_out <= next_dq_out;
            o_dq_oe <= next_dq_oe;
            o_rd_valid <= next_rd_valid;
            o_rd_data <= next_rd_data;
        end
    end

    assign o_req_ready = (state == ST_IDLE) && !supply_low;
endmodule // sram_host_ctrl

// [bench/sram_device_model.sv]
// Behavioural model of the 64K x 16 static memory on the controller pins
module sram_device_model
    import sram_host_pkg::*;
#(
    parameter int ACC_NS = 14
) (
    // Memory pins from the host
    input wire logic [`ADDR_W-1:0] i_addr,
    input wire sram_ctl_type i_ctl,
    input wire logic [`DATA_W-1:0] i_dq_out,
    input wire logic i_dq_oe,
    // Data line level and contention flag
    output logic [`DATA_W-1:0] o_level,
    output logic o_clash
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:65535];
    logic [15:0] word;
    logic [1:0] lane_rd;
    logic rd_mode;
    initial foreach (mem[i]) mem[i] = 16'h0000;
    assign rd_mode = !i_ctl.chip_sel_n && i_ctl.write_en_n && !i_ctl.out_en_n;
    assign lane_rd = {2{rd_mode}} & ~{i_ctl.high_byte_en_n, i_ctl.low_byte_en_n};
    assign word = mem[i_addr];
    always @* begin
        if (!i_ctl.chip_sel_n && !i_ctl.write_en_n && i_dq_oe) begin
            if (!i_ctl.low_byte_en_n) mem[i_addr][7:0] = i_dq_out[7:0];
            if (!i_ctl.high_byte_en_n) mem[i_addr][15:8] = i_dq_out[15:8];
        end
    end
    // Slow but inside the access limit; a floating lane shows the inverse word
    assign #(ACC_NS) o_level = i_dq_oe ? i_dq_out : {lane_rd[1] ? word[15:8] : ~word[15:8],
        lane_rd[0] ? word[7:0] : ~word[7:0]};
    assign o_clash = i_dq_oe && rd_mode;
endmodule // sram_device_model

// [bench/sram_host_ctrl_properties.sv]
// Pin timing properties of the static memory host controller
module sram_host_ctrl_props
    import sram_host_pkg::*;
#(
    parameter int unsigned RDR_CYC = 8
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Host side
    input wire logic i_req_valid,
    input wire host_req_type i_req,
    input wire logic o_req_ready,
    input wire logic o_rd_valid,
    input wire logic [`DATA_W-1:0] o_rd_data,
    input wire logic i_low_supply,
    // Memory pins
    input wire logic [`ADDR_W-1:0] o_sram_addr,
    input wire sram_ctl_type o_sram_ctl,
    input wire logic [`DATA_W-1:0] o_dq_out,
    input wire logic o_dq_oe,
    input wire logic [`DATA_W-1:0] i_dq_in
);
    logic [31:0] quiet;
    logic [31:0] next_quiet;
    logic take;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    assign take = i_req_valid && o_req_ready;
    // Saturates, so a reset counts as a long settled supply
    always_comb next_quiet = i_low_supply ? 32'h0 : quiet + 32'(quiet != 32'hFFFFFFFF);
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) quiet <= 32'hFFFFFFFF;
        else quiet <= next_quiet;
    end
    a_read_we_high: assert property (!o_sram_ctl.out_en_n |-> o_sram_ctl.write_en_n)
        else $error("strobe low in read");
    a_read_window: assert property ($fell(o_sram_ctl.out_en_n) |-> (!o_sram_ctl.chip_sel_n &&
        !o_sram_ctl.out_en_n)[*4] ##1 o_sram_ctl == CTL_IDLE) else $error("read window wrong");
    a_no_drive_read: assert property (o_dq_oe |-> o_sram_ctl.out_en_n &&
        $past(o_sram_ctl.out_en_n)) else $error("data driven near read");
    a_strobe_with_select: assert property ($fell(o_sram_ctl.write_en_n) |->
        $fell(o_sram_ctl.chip_sel_n) && o_dq_oe) else $error("select not with strobe");
    a_write_pulse: assert property ($fell(o_sram_ctl.write_en_n) |=> $rose(o_sram_ctl.write_en_n) &&
        $rose(o_sram_ctl.chip_sel_n) && $stable(o_sram_addr) && $stable(o_dq_out))
        else $error("write pulse wrong");
    a_write_spacing: assert property ($rose(o_sram_ctl.write_en_n) |-> o_sram_ctl.write_en_n[*2])
        else $error("writes too close");
    a_write_issue: assert property (take && i_req.write |=> !o_sram_ctl.write_en_n &&
        o_sram_addr == $past(i_req.addr) && o_dq_out == $past(i_req.wdata))
        else $error("write pins wrong");
    a_read_answer: assert property (take && !i_req.write |=> !o_rd_valid[*4] ##1 o_rd_valid)
        else $error("read answer late");
    a_recovery_wait: assert property ($rose(o_req_ready) |-> quiet >= RDR_CYC)
        else $error("ready before recovery");
    a_retention_idle: assert property (i_low_supply[*6] |-> !o_req_ready)
        else $error("ready in retention");
    c_read: cover property (take && !i_req.write);
    c_write: cover property (take && i_req.write);
    c_recover: cover property ($fell(i_low_supply));
endmodule // sram_host_ctrl_props
bind sram_host_ctrl sram_host_ctrl_props #(.RDR_CYC(RDR_CYC)) u_props (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .i_low_supply(i_low_supply),
    .o_sram_addr(o_sram_addr), .o_sram_ctl(o_sram_ctl), .o_dq_out(o_dq_out),
    .o_dq_oe(o_dq_oe), .i_dq_in(i_dq_in));

// [bench/testbench.sv]
// Self-checking bench for the static memory host controller
module testbench
    import sram_host_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RDR = 8;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_req_valid = 1'b0;
    host_req_type i_req = '0;
    logic i_low_supply = 1'b0;
    logic o_req_ready, o_rd_valid, o_dq_oe, clash;
    logic [15:0] o_rd_data, o_sram_addr, o_dq_out, i_dq_in;
    sram_ctl_type o_sram_ctl;
    logic [15:0] shadow [logic [15:0]];
    int errors = 0;
    int checks = 0;
    int clashes = 0;
    always #20 i_ref_clk = ~i_ref_clk;
    sram_host_ctrl #(.RDR_CYC(RDR)) uut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
        .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .i_low_supply(i_low_supply),
        .o_sram_addr(o_sram_addr), .o_sram_ctl(o_sram_ctl), .o_dq_out(o_dq_out),
        .o_dq_oe(o_dq_oe), .i_dq_in(i_dq_in));
    sram_device_model #(.ACC_NS(14)) mem_model (.i_addr(o_sram_addr), .i_ctl(o_sram_ctl),
        .i_dq_out(o_dq_out), .i_dq_oe(o_dq_oe), .o_level(i_dq_in), .o_clash(clash));
    always @(posedge i_ref_clk) if (clash !== 1'b0 && i_rst_n) clashes++;
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [15:0] expect_rd(logic [15:0] a, logic [1:0] en_n);
        logic [15:0] w;
        w = shadow.exists(a) ? shadow[a] : 16'h0000;
        return w & {{8{!en_n[1]}}, {8{!en_n[0]}}};
    endfunction
    // Request held from one falling edge until the edge that takes it
    task automatic access(logic wr, logic [15:0] a, logic [15:0] d, logic [1:0] en_n);
        int n;
        n = 0;
        @(negedge i_ref_clk);
        i_req_valid = 1'b1;
        i_req = '{wr, a, d, en_n[1], en_n[0]};
        while (o_req_ready !== 1'b1 && n < 400) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk("taken", 16'h0000, 16'(n >= 400));
        @(negedge i_ref_clk);
        i_req_valid = 1'b0;
        if (wr) begin
            if (!shadow.exists(a)) shadow[a] = 16'h0000;
            if (!en_n[0]) shadow[a][7:0] = d[7:0];
            if (!en_n[1]) shadow[a][15:8] = d[15:8];
        end else begin
            n = 0;
            while (o_rd_valid !== 1'b1 && n < 20) begin
                @(negedge i_ref_clk);
                n++;
            end
            chk("read wait", 16'h0004, 16'(n));
            chk("read data", expect_rd(a, en_n), o_rd_data);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        give_verdict();
    end
    initial begin
        logic [15:0] a;
        int n;
        void'($urandom(69386));
        repeat (4) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        i_rst_n = 1'b1;
        access(1'b1, 16'h0000, 16'h1234, 2'b00);
        access(1'b1, 16'hFFFF, 16'hBEEF, 2'b00);
        access(1'b1, 16'hFFFF, 16'h5500, 2'b10);
        access(1'b0, 16'hFFFF, 16'h0000, 2'b00);
        access(1'b0, 16'h0000, 16'h0000, 2'b01);
        access(1'b1, 16'h0000, 16'hAAAA, 2'b11);
        access(1'b0, 16'h0000, 16'h0000, 2'b00);
        repeat (40) begin
            a = {3'($urandom), 13'h0ABC};
            access(1'($urandom), a, 16'($urandom), 2'($urandom));
        end
        @(negedge i_ref_clk);
        i_low_supply = 1'b1;
        repeat (8) @(negedge i_ref_clk);
        chk("ready in retention", 16'h0000, {15'h0, o_req_ready});
        i_low_supply = 1'b0;
        n = 0;
        while (o_req_ready !== 1'b1 && n < 100) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk("recovery span", 16'h0001, 16'(n >= RDR && n <= RDR + 8));
        // Supply drops again while recovering, so the wait must start over
        i_low_supply = 1'b1;
        repeat (8) @(negedge i_ref_clk);
        i_low_supply = 1'b0;
        repeat (5) @(negedge i_ref_clk);
        i_low_supply = 1'b1;
        n = 0;
        repeat (12) begin
            @(negedge i_ref_clk);
            n += int'(o_req_ready !== 1'b0);
        end
        chk("ready in second drop", 16'h0000, 16'(n));
        i_low_supply = 1'b0;
        n = 0;
        while (o_req_ready !== 1'b1 && n < 100) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk("recovery restart", 16'h0001, 16'(n >= RDR && n <= RDR + 8));
        access(1'b0, 16'hFFFF, 16'h0000, 2'b00);
        chk("contention", 16'h0000, 16'(clashes));
        give_verdict();
    end
endmodule // testbench
